// ### shared/tcs_pkg.sv
package tcs_pkg;

  // ********************************
  // Widths
  // ********************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int TORQ_W = 16;

  // ********************************
  // Register indexes and byte addresses
  // ********************************
  localparam logic [9:0] IDX_CTRL_MODE = 10'h101;
  localparam logic [9:0] IDX_LIMIT_EN = 10'h102;
  localparam logic [9:0] IDX_SMOOTH = 10'h107;
  localparam logic [9:0] IDX_PRESET_1 = 10'h10C;
  localparam logic [9:0] IDX_PRESET_2 = 10'h10D;
  localparam logic [9:0] IDX_PRESET_3 = 10'h10E;
  localparam logic [9:0] IDX_FULL_SCALE = 10'h129;
  localparam logic [9:0] IDX_STATUS = 10'h1F0;
  localparam logic [9:0] IDX_COMMAND = 10'h1F1;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_MODE = {IDX_CTRL_MODE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_LIMIT_EN = {IDX_LIMIT_EN, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SMOOTH = {IDX_SMOOTH, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PRESET_1 = {IDX_PRESET_1, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PRESET_2 = {IDX_PRESET_2, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PRESET_3 = {IDX_PRESET_3, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_FULL_SCALE = {IDX_FULL_SCALE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = {IDX_COMMAND, 2'h0};

  // ********************************
  // Reset values and limits
  // ********************************
  localparam logic [15:0] RST_SMOOTH = 16'h0000;
  localparam logic [15:0] RST_FULL_SCALE = 16'h0064;
  localparam logic [15:0] RST_PRESET = 16'h0000;
  localparam logic [15:0] SMOOTH_MAX_MS = 16'h03E8;
  localparam logic signed [15:0] PRESET_MAX = 16'sh012C;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  // ********************************
  // Fields
  // ********************************
  localparam int MODE_LSB = 0;
  localparam int LIMIT_EN_BIT = 0;
  localparam int ST_SERVO_BIT = 0;
  localparam int ST_ARMED_BIT = 1;
  localparam int ST_SEL_LSB = 2;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_SRC_LSB = 6;
  localparam int ST_LIMIT_BIT = 8;
  localparam int ST_COEF_BUSY_BIT = 9;

  // ********************************
  // Scaling: code 2**14 stands for 10 V
  // ********************************
  localparam int ANALOG_FS_SHIFT = 14;
  localparam int FULL_SCALE_VOLTS = 10;
  localparam int TENTHS_PER_PCT = 10;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int SAMPLE_TIME_US = 100;
  localparam int NS_PER_US = 1000;
  localparam int US_PER_MS = 1000;
  localparam int SAMPLE_CYCLES = (SAMPLE_TIME_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int COEF_FRAC = 16;

  // ********************************
  // Types
  // ********************************
  typedef enum logic [1:0] {
    MODE_POSITION = 2'h0,
    MODE_SPEED = 2'h1,
    MODE_TORQUE = 2'h2,
    MODE_ZERO_TORQUE = 2'h3
  } tcs_mode_e;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_ANALOG = 2'h1,
    SRC_PRESET = 2'h2
  } tcs_src_e;

  typedef struct packed {
    logic signed [TORQ_W-1:0] demand;
    logic [TORQ_W-1:0] limit;
    logic limitActive;
    logic torqueMode;
  } tcs_cmd_s;

endpackage : tcs_pkg

// ### design/tcs_analog_scale.sv
`timescale 1ns/10ps
module tcs_analog_scale #(
  parameter int TORQ_W = tcs_pkg::TORQ_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Analog code and scale
  input wire logic signed [TORQ_W-1:0] analogCode,
  input wire logic [15:0] fullScale,
  // Torque in tenths of a percent
  output logic signed [TORQ_W-1:0] torqueTenths
);

  // ********************************
  // Volts times setting over ten, in tenths
  // ********************************
  localparam int PROD_W = TORQ_W + 17 + 5;
  localparam logic signed [PROD_W-1:0] MAX_OUT = PROD_W'((1 <<< (TORQ_W - 1)) - 1);
  localparam logic signed [PROD_W-1:0] MIN_OUT = -MAX_OUT;
  localparam logic signed [5:0] GAIN =
    6'(tcs_pkg::TENTHS_PER_PCT * tcs_pkg::FULL_SCALE_VOLTS / tcs_pkg::FULL_SCALE_VOLTS);

  wire logic signed [16:0] fsSigned = {1'b0, fullScale};
  wire logic signed [PROD_W-1:0] product =
    PROD_W'(analogCode) * PROD_W'(fsSigned) * PROD_W'(GAIN); // see RULE_09
  wire logic signed [PROD_W-1:0] scaled = product >>> tcs_pkg::ANALOG_FS_SHIFT; // see RULE_10
  // Saturate symmetric so the magnitude never overflows
  wire logic signed [TORQ_W-1:0] clipped =
    (scaled > MAX_OUT) ? MAX_OUT[TORQ_W-1:0] :
    (scaled < MIN_OUT) ? MIN_OUT[TORQ_W-1:0] : scaled[TORQ_W-1:0];

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      torqueTenths <= '0;
    else
      torqueTenths <= clipped;
  end

endmodule : tcs_analog_scale

// ### design/tcs_smooth_filter.sv
`timescale 1ns/10ps
module tcs_smooth_filter #(
  parameter int TORQ_W = tcs_pkg::TORQ_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic sampleTick,
  input wire logic tauLoad,
  input wire logic [15:0] tauMs,
  input wire logic bypass,
  // Data
  input wire logic signed [TORQ_W-1:0] dataIn,
  output logic signed [TORQ_W-1:0] dataOut,
  output logic coefBusy
);

  // ********************************
  // Coefficient Ts / (tau + Ts) by serial division
  // ********************************
  localparam int FR = tcs_pkg::COEF_FRAC;
  localparam int NUM_W = 24;
  localparam int DEN_W = 20;
  localparam int CNT_W = 5;
  localparam int ACC_W = TORQ_W + FR + 1;
  localparam logic [NUM_W-1:0] NUM = NUM_W'(tcs_pkg::SAMPLE_TIME_US << FR);
  localparam logic [DEN_W-1:0] TS_US = DEN_W'(tcs_pkg::SAMPLE_TIME_US);
  localparam logic [DEN_W-1:0] US_PER_MS = DEN_W'(tcs_pkg::US_PER_MS);
  localparam logic [CNT_W-1:0] STEPS = CNT_W'(NUM_W);
  localparam logic [FR:0] COEF_ONE = {1'b1, {FR{1'b0}}};

  logic [DEN_W-1:0] den_r;
  logic [DEN_W-1:0] rem_r;
  logic [NUM_W-1:0] numSh_r;
  logic [NUM_W-1:0] quo_r;
  logic [CNT_W-1:0] cnt_r;
  logic [FR:0] coef_r;
  logic signed [ACC_W-1:0] acc_r;

  wire logic [DEN_W-1:0] den = DEN_W'(tauMs * US_PER_MS) + TS_US;
  wire logic [DEN_W:0] remShift = {rem_r, numSh_r[NUM_W-1]};
  wire logic fits = remShift >= {1'b0, den_r};
  wire logic [DEN_W:0] remSub = remShift - {1'b0, den_r};
  wire logic [DEN_W-1:0] remNxt = fits ? remSub[DEN_W-1:0] : remShift[DEN_W-1:0];
  wire logic [NUM_W-1:0] quoNxt = {quo_r[NUM_W-2:0], fits};

  // Old coefficient stays in use while a new one is computed
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      den_r <= '0;
      rem_r <= '0;
      numSh_r <= '0;
      quo_r <= '0;
      cnt_r <= '0;
      coefBusy <= 1'b0;
      coef_r <= COEF_ONE;
    end
    else if (tauLoad)
    begin
      den_r <= den;
      rem_r <= '0;
      numSh_r <= NUM;
      quo_r <= '0;
      cnt_r <= STEPS;
      coefBusy <= 1'b1;
    end
    else if (coefBusy)
    begin
      rem_r <= remNxt;
      numSh_r <= {numSh_r[NUM_W-2:0], 1'b0};
      quo_r <= quoNxt;
      cnt_r <= cnt_r - 1'b1;
      if (cnt_r == CNT_W'(1))
      begin
        coefBusy <= 1'b0;
        coef_r <= quoNxt[FR:0]; // see RULE_14
      end
    end
  end

  // ********************************
  // First-order recursion, once per sample
  // ********************************
  wire logic signed [TORQ_W:0] diff = dataIn - dataOut;
  wire logic signed [FR+1:0] coefS = {1'b0, coef_r};
  wire logic signed [ACC_W-1:0] step = ACC_W'(diff) * ACC_W'(coefS);
  wire logic signed [ACC_W-1:0] loadIn = {dataIn[TORQ_W-1], dataIn, {FR{1'b0}}};

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      acc_r <= '0;
    else if (bypass)
      acc_r <= loadIn; // see RULE_08
    else if (sampleTick)
      acc_r <= acc_r + step; // see RULE_14
  end

  assign dataOut = acc_r[FR+TORQ_W-1:FR];

endmodule : tcs_smooth_filter

// ### design/tcs_torque_command_select.sv
// Overview of operation
// RULE_01: Selects 00 in torque mode: command is scaled analog reference.
// RULE_02: Selects 00 in zero-torque mode: command forced to zero.
// RULE_03: Selects 01, 10, 11 pick first, second, third preset, each within 300 percent.
// RULE_04: A preset acts only after a select input has changed.
// RULE_05: Select input 0 means off, 1 means on.
// RULE_06: In position and speed modes the command becomes a torque limit.
// RULE_07: Source chosen from both select inputs plus the mode setting.
// RULE_08: Torque mode analog command is low-pass smoothed; zero time bypasses.
// RULE_09: Analog torque equals volts times full-scale setting over ten.
// RULE_10: Full-scale setting is the torque or limit at ten volts.
// RULE_11: Selection only acts after servo-on.
// RULE_12: No current loop gains are settable; fixed gains only.
// RULE_13: Torque limit active only when its enable bit is one.
// RULE_14: Smoothing is a first-order recursion per sample period.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
module tcs_torque_command_select #(
  parameter int TORQ_W = tcs_pkg::TORQ_W,
  parameter int SAMPLE_CYCLES = tcs_pkg::SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [tcs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [tcs_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [tcs_pkg::DATA_W-1:0] regRdData,
  // Drive inputs
  input wire logic torque_select_bit0,
  input wire logic torque_select_bit1,
  input wire logic servoOn,
  input wire logic signed [TORQ_W-1:0] analogCode,
  // Command out
  output tcs_pkg::tcs_cmd_s torqueCmd
);

  // ********************************
  // Constants
  // ********************************
  localparam int TICK_W = $clog2(SAMPLE_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_CYCLES - 1);
  localparam logic signed [TORQ_W-1:0] TORQ_ZERO = '0;

  // ********************************
  // Registers
  // ********************************
  tcs_pkg::tcs_mode_e mode_r;
  logic limitEn_r;
  logic [15:0] smoothTime_r;
  logic [15:0] fullScale_r;
  logic signed [15:0] preset1_r;
  logic signed [15:0] preset2_r;
  logic signed [15:0] preset3_r;
  logic [1:0] selPrev_r;
  logic armed_r;
  logic [TICK_W-1:0] tick_r;
  logic sampleTick_r;
  logic tauLoad_r;
  logic [tcs_pkg::DATA_W-1:0] rdData_r;
  tcs_pkg::tcs_cmd_s cmd_r;

  // ********************************
  // Address decode
  // ********************************
  wire logic hitMode = regAddr == tcs_pkg::ADDR_CTRL_MODE;
  wire logic hitLimEn = regAddr == tcs_pkg::ADDR_LIMIT_EN;
  wire logic hitSmooth = regAddr == tcs_pkg::ADDR_SMOOTH;
  wire logic hitPre1 = regAddr == tcs_pkg::ADDR_PRESET_1;
  wire logic hitPre2 = regAddr == tcs_pkg::ADDR_PRESET_2;
  wire logic hitPre3 = regAddr == tcs_pkg::ADDR_PRESET_3;
  wire logic hitFs = regAddr == tcs_pkg::ADDR_FULL_SCALE;
  wire logic hitStatus = regAddr == tcs_pkg::ADDR_STATUS;
  wire logic hitCmd = regAddr == tcs_pkg::ADDR_COMMAND;

  wire logic [15:0] wrLow = regWrData[15:0];
  wire logic signed [15:0] wrSigned = regWrData[15:0];
  // Presets clip to +/-300 percent on write
  wire logic signed [15:0] presetClip =
    (wrSigned > tcs_pkg::PRESET_MAX) ? tcs_pkg::PRESET_MAX :
    (wrSigned < -tcs_pkg::PRESET_MAX) ? -tcs_pkg::PRESET_MAX : wrSigned; // see RULE_03
  // Out-of-range time clips to the longest constant
  wire logic [15:0] smoothClip =
    (wrLow > tcs_pkg::SMOOTH_MAX_MS) ? tcs_pkg::SMOOTH_MAX_MS : wrLow;
  wire tcs_pkg::tcs_mode_e modeWr =
    tcs_pkg::tcs_mode_e'(regWrData[tcs_pkg::MODE_LSB +: 2]);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      mode_r <= tcs_pkg::MODE_POSITION;
      limitEn_r <= 1'b0;
      smoothTime_r <= tcs_pkg::RST_SMOOTH;
      fullScale_r <= tcs_pkg::RST_FULL_SCALE;
      preset1_r <= tcs_pkg::RST_PRESET;
      preset2_r <= tcs_pkg::RST_PRESET;
      preset3_r <= tcs_pkg::RST_PRESET;
    end
    else if (regWrEn)
    begin
      if (hitMode)
        mode_r <= modeWr;
      if (hitLimEn)
        limitEn_r <= regWrData[tcs_pkg::LIMIT_EN_BIT];
      if (hitSmooth)
        smoothTime_r <= smoothClip;
      if (hitFs)
        fullScale_r <= wrLow;
      if (hitPre1)
        preset1_r <= presetClip;
      if (hitPre2)
        preset2_r <= presetClip;
      if (hitPre3)
        preset3_r <= presetClip;
    end
  end

  // A new time constant restarts the coefficient divider
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      tauLoad_r <= 1'b1;
    else
      tauLoad_r <= regWrEn && hitSmooth;
  end

  // ********************************
  // Sample period tick
  // ********************************
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tick_r <= '0;
      sampleTick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (tick_r == TICK_LAST) ? '0 : tick_r + 1'b1;
      sampleTick_r <= tick_r == TICK_LAST; // see RULE_14
    end
  end

  // ********************************
  // Select inputs and arming
  // ********************************
  // Pin high means the contact is closed
  wire logic [1:0] sel = {torque_select_bit1, torque_select_bit0}; // see RULE_05
  wire logic selChanged = sel != selPrev_r;

  // Arming is lost at servo-off so a stale pattern never applies
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      selPrev_r <= 2'h0;
      armed_r <= 1'b0;
    end
    else
    begin
      selPrev_r <= sel;
      if (!servoOn)
        armed_r <= 1'b0; // see RULE_11
      else if (selChanged)
        armed_r <= 1'b1; // see RULE_04
    end
  end

  // ********************************
  // Analog path
  // ********************************
  logic signed [TORQ_W-1:0] analogScaled;
  logic signed [TORQ_W-1:0] analogSmooth;
  logic coefBusy;

  tcs_analog_scale #(
    .TORQ_W(TORQ_W)
  ) u_scale (
    .clk_sys(clk_sys),
    .reset(reset),
    .analogCode(analogCode),
    .fullScale(fullScale_r),
    .torqueTenths(analogScaled)
  );

  wire logic torqueMode =
    (mode_r == tcs_pkg::MODE_TORQUE) || (mode_r == tcs_pkg::MODE_ZERO_TORQUE);
  // Limit use and zero time take the raw scaled value
  wire logic smoothBypass = !torqueMode || (smoothTime_r == 16'h0000); // see RULE_08

  tcs_smooth_filter #(
    .TORQ_W(TORQ_W)
  ) u_smooth (
    .clk_sys(clk_sys),
    .reset(reset),
    .sampleTick(sampleTick_r),
    .tauLoad(tauLoad_r),
    .tauMs(smoothTime_r),
    .bypass(smoothBypass),
    .dataIn(analogScaled),
    .dataOut(analogSmooth),
    .coefBusy(coefBusy)
  );

  wire logic signed [TORQ_W-1:0] analogCmd = torqueMode ? analogSmooth : analogScaled;

  // ********************************
  // Source selection
  // ********************************
  wire logic signed [15:0] presetPct =
    (sel == 2'h1) ? preset1_r :
    (sel == 2'h2) ? preset2_r : preset3_r; // see RULE_03
  // Presets are percent, the command is tenths of a percent
  wire logic signed [TORQ_W-1:0] presetTenths =
    TORQ_W'(presetPct * 16'sd10);
  wire logic zeroMode = mode_r == tcs_pkg::MODE_ZERO_TORQUE;

  wire tcs_pkg::tcs_src_e src =
    !servoOn ? tcs_pkg::SRC_NONE : // see RULE_11
    (sel == 2'h0) ? (zeroMode ? tcs_pkg::SRC_NONE : tcs_pkg::SRC_ANALOG) : // see RULE_07
    (armed_r ? tcs_pkg::SRC_PRESET : tcs_pkg::SRC_NONE); // see RULE_04

  wire logic signed [TORQ_W-1:0] selected =
    (src == tcs_pkg::SRC_ANALOG) ? analogCmd : // see RULE_01
    (src == tcs_pkg::SRC_PRESET) ? presetTenths : TORQ_ZERO; // see RULE_02

  wire logic [TORQ_W-1:0] selMag = selected[TORQ_W-1] ? TORQ_W'(-selected) : selected;
  wire logic limitOn = !torqueMode && limitEn_r && servoOn; // see RULE_13

  // ********************************
  // Command output
  // ********************************
  tcs_pkg::tcs_cmd_s cmdNxt;
  assign cmdNxt.demand = torqueMode ? selected : TORQ_ZERO; // see RULE_06
  assign cmdNxt.limit = limitOn ? selMag : '0; // see RULE_06
  assign cmdNxt.limitActive = limitOn; // see RULE_13
  assign cmdNxt.torqueMode = torqueMode;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cmd_r <= '0;
    else
      cmd_r <= cmdNxt;
  end

  assign torqueCmd = cmd_r;

  // ********************************
  // Read back
  // ********************************
  logic [tcs_pkg::DATA_W-1:0] statusWord;
  always_comb
  begin
    statusWord = tcs_pkg::READ_ZERO;
    statusWord[tcs_pkg::ST_SERVO_BIT] = servoOn;
    statusWord[tcs_pkg::ST_ARMED_BIT] = armed_r;
    statusWord[tcs_pkg::ST_SEL_LSB +: 2] = sel;
    statusWord[tcs_pkg::ST_MODE_LSB +: 2] = mode_r;
    statusWord[tcs_pkg::ST_SRC_LSB +: 2] = src;
    statusWord[tcs_pkg::ST_LIMIT_BIT] = cmd_r.limitActive;
    statusWord[tcs_pkg::ST_COEF_BUSY_BIT] = coefBusy;
  end

  wire logic [TORQ_W-1:0] cmdShown = cmd_r.torqueMode ? cmd_r.demand : cmd_r.limit;

  // Current loop gains have no address, unmapped reads give zero
  wire logic [tcs_pkg::DATA_W-1:0] rdMux =
    hitMode ? {30'h0000_0000, mode_r} :
    hitLimEn ? {31'h0000_0000, limitEn_r} :
    hitSmooth ? {16'h0000, smoothTime_r} :
    hitFs ? {16'h0000, fullScale_r} :
    hitPre1 ? {{16{preset1_r[15]}}, preset1_r} :
    hitPre2 ? {{16{preset2_r[15]}}, preset2_r} :
    hitPre3 ? {{16{preset3_r[15]}}, preset3_r} :
    hitStatus ? statusWord :
    hitCmd ? {{16{cmdShown[TORQ_W-1]}}, cmdShown} : tcs_pkg::READ_ZERO; // see RULE_12

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rdData_r <= tcs_pkg::READ_ZERO;
    else if (regRdEn)
      rdData_r <= rdMux;
    else
      rdData_r <= tcs_pkg::READ_ZERO;
  end

  assign regRdData = rdData_r;

endmodule : tcs_torque_command_select

// ### tb/tcs_torque_command_select_assertions.sv
`timescale 1ns/10ps
module tcs_sva_checker #(
  parameter int TORQ_W = tcs_pkg::TORQ_W,
  parameter int SAMPLE_CYCLES = tcs_pkg::SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [tcs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [tcs_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [tcs_pkg::DATA_W-1:0] regRdData,
  // Drive inputs
  input wire logic torque_select_bit0,
  input wire logic torque_select_bit1,
  input wire logic servoOn,
  input wire logic signed [TORQ_W-1:0] analogCode,
  // Command out
  input wire tcs_pkg::tcs_cmd_s torqueCmd
);
  // ****************
  // Sequences
  // ****************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  wire logic [1:0] selNow = {torque_select_bit1, torque_select_bit0};
  wire logic cmdIdle = (torqueCmd.demand == '0) && (torqueCmd.limit == '0);
  sequence servoHeldOff;
    !servoOn ##1 !servoOn;
  endsequence
  sequence selStep;
    servoOn && (selNow != 2'h0) && !$stable(selNow);
  endsequence
  // Selects already closed at servo-on and never moved since
  sequence onWithoutStep;
    !servoOn ##1 (servoOn && (selNow != 2'h0) && $stable(selNow))
      ##1 (servoOn && $stable(selNow)) [*2];
  endsequence
  // ****************
  // Assertions
  // ****************
  a_servo_off_idle: assert property (servoHeldOff |=> cmdIdle)
    else $error("Command not idle while servo is off");
  a_unarmed_idle: assert property (onWithoutStep |=> cmdIdle)
    else $error("Preset acted before any select change");
  a_preset_range: assert property (selStep ##1 (servoOn && $stable(selNow)) [*2] |->
    (torqueCmd.demand <= 16'sh0BB8) && (torqueCmd.demand >= -16'sh0BB8)
    && (torqueCmd.limit <= 16'h0BB8))
    else $error("Preset command beyond 300 percent");
  a_torque_no_limit: assert property (torqueCmd.torqueMode |->
    (torqueCmd.limit == '0) && !torqueCmd.limitActive)
    else $error("Limit driven in torque mode");
  a_limit_no_demand: assert property (!torqueCmd.torqueMode |-> torqueCmd.demand == '0)
    else $error("Demand driven in position or speed mode");
  a_limit_gated: assert property (!torqueCmd.limitActive |-> torqueCmd.limit == '0)
    else $error("Limit value while limit is off");
  a_read_idle_zero: assert property (!regRdEn |=> regRdData == '0)
    else $error("Read data outside the read answer cycle");
  a_unmapped_zero: assert property (regRdEn && (regAddr == 12'hFFC) |=> regRdData == '0)
    else $error("Unmapped address read not zero");
  a_reset_clears: assert property ($fell(reset) |-> torqueCmd == '0)
    else $error("Command not cleared by reset");
endmodule : tcs_sva_checker

bind tcs_torque_command_select tcs_sva_checker #(
  .TORQ_W(TORQ_W),
  .SAMPLE_CYCLES(SAMPLE_CYCLES)
) chk_u (
  .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .torque_select_bit0(torque_select_bit0), .torque_select_bit1(torque_select_bit1),
  .servoOn(servoOn), .analogCode(analogCode), .torqueCmd(torqueCmd)
);

// ### tb/tcs_host_model.sv
`timescale 1ns/10ps
module tcs_host_model (
  // Clock
  input wire logic clk_sys,
  // Requests from the bench
  input wire logic wantServo,
  input wire logic [1:0] wantSel,
  input wire logic signed [15:0] wantCode,
  input wire logic earlySel,
  // Drive pins
  output logic servoOn,
  output logic torque_select_bit0,
  output logic torque_select_bit1,
  output logic signed [15:0] analogCode
);
  logic [1:0] sel_r = 2'h0;
  initial servoOn = 1'b0;
  initial analogCode = 16'sh0000;
  // 1 closes the contact, 0 leaves it open
  assign torque_select_bit0 = sel_r[0];
  assign torque_select_bit1 = sel_r[1];
  always @(posedge clk_sys)
  begin
    servoOn <= wantServo;
    analogCode <= wantCode;
    // Contacts stay open until servo-on; earlySel only for the misuse case
    sel_r <= (servoOn || earlySel) ? wantSel : 2'h0;
  end
endmodule : tcs_host_model

// ### tb/tcs_torque_command_select_tb_top.sv
`timescale 1ns/10ps
module tcs_torque_command_select_tb_top;
  // ****************
  // Bench signals
  // ****************
  localparam int SAMPLES = 16;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [tcs_pkg::ADDR_W-1:0] regAddr = 12'h000;
  logic [tcs_pkg::DATA_W-1:0] regWrData = 32'h0000_0000;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [tcs_pkg::DATA_W-1:0] regRdData;
  logic wantServo = 1'b0;
  logic earlySel = 1'b0;
  logic [1:0] wantSel = 2'h0;
  logic signed [15:0] wantCode = 16'sh0000;
  logic selBit0;
  logic selBit1;
  logic servoOn;
  logic signed [15:0] analogCode;
  tcs_pkg::tcs_cmd_s torqueCmd;
  logic [31:0] lfsr = 32'h0001_740B; // 95243
  int mismatches = 0;
  int checksDone = 0;
  int code;
  int fs;
  logic signed [15:0] d1;
  logic [11:0] rstAddr [8] = '{tcs_pkg::ADDR_CTRL_MODE, tcs_pkg::ADDR_LIMIT_EN,
    tcs_pkg::ADDR_SMOOTH, tcs_pkg::ADDR_PRESET_1, tcs_pkg::ADDR_PRESET_2,
    tcs_pkg::ADDR_PRESET_3, tcs_pkg::ADDR_FULL_SCALE, 12'hFFC};
  logic [31:0] rstVal [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0064, 32'h0};
  logic [31:0] presetExp [4] = '{32'h0, 32'h0000_0BB8, 32'hFFFF_F448, 32'h0000_04CE};

  always #4 clk_sys = ~clk_sys;

  tcs_torque_command_select #(.TORQ_W(16), .SAMPLE_CYCLES(SAMPLES)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .torque_select_bit0(selBit0), .torque_select_bit1(selBit1), .servoOn(servoOn),
    .analogCode(analogCode), .torqueCmd(torqueCmd));

  tcs_host_model host_u (
    .clk_sys(clk_sys), .wantServo(wantServo), .wantSel(wantSel), .wantCode(wantCode),
    .earlySel(earlySel), .servoOn(servoOn), .torque_select_bit0(selBit0),
    .torque_select_bit1(selBit1), .analogCode(analogCode));

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  // Saturating volts times full scale over ten, in tenths of a percent
  function automatic logic signed [15:0] scale_exp(input int c, input int f);
    longint p;
    p = (longint'(c) * f * tcs_pkg::TENTHS_PER_PCT) >>> tcs_pkg::ANALOG_FS_SHIFT;
    if (p > 32767)
      p = 32767;
    if (p < -32767)
      p = -32767;
    return p[15:0];
  endfunction : scale_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask : rd

  task automatic settle();
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic host(input logic s, input logic [1:0] sel, input int c, input logic e);
    @(posedge clk_sys);
    wantServo <= s;
    wantSel <= sel;
    wantCode <= 16'(c);
    earlySel <= e;
    settle();
  endtask : host

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // ****************
  // Scenarios
  // ****************
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (rstAddr[i]) rd(rstAddr[i], rstVal[i]);
    wr(tcs_pkg::ADDR_PRESET_1, 32'h0000_015E);
    wr(tcs_pkg::ADDR_PRESET_2, 32'h0000_FE70);
    wr(tcs_pkg::ADDR_PRESET_3, 32'h0000_007B);
    wr(tcs_pkg::ADDR_SMOOTH, 32'h0000_07D0);
    rd(tcs_pkg::ADDR_PRESET_1, 32'h0000_012C);
    rd(tcs_pkg::ADDR_PRESET_2, 32'hFFFF_FED4);
    rd(tcs_pkg::ADDR_PRESET_3, 32'h0000_007B);
    rd(tcs_pkg::ADDR_SMOOTH, 32'h0000_03E8);
    wr(tcs_pkg::ADDR_SMOOTH, 32'h0000_0000);
    wr(tcs_pkg::ADDR_CTRL_MODE, 32'h0000_0002);
    // First two are the full-swing and saturation corners
    for (int i = 0; i < 14; i++)
    begin
      lfsr = next_rand(lfsr);
      code = (i == 0) ? 32'sh4000 : (i == 1) ? -32'sh4000 : int'(lfsr[23:9]) - 32'sh4000;
      fs = (i == 0) ? 32'h64 : (i == 1) ? 32'hFA0 : int'(lfsr[7:0]) + 1;
      wr(tcs_pkg::ADDR_FULL_SCALE, 32'(fs));
      host(1'b1, 2'h0, code, 1'b0);
      chk(torqueCmd.demand, scale_exp(code, fs));
      chk({30'h0, torqueCmd.torqueMode, torqueCmd.limitActive}, 32'h2);
    end
    wr(tcs_pkg::ADDR_CTRL_MODE, 32'h0000_0003);
    settle();
    chk(torqueCmd.demand, 32'h0);
    for (int s = 1; s < 4; s++)
    begin
      host(1'b1, 2'(s), code, 1'b0);
      chk(torqueCmd.demand, presetExp[s]);
    end
    host(1'b0, 2'h0, code, 1'b0);
    chk(torqueCmd.demand, 32'h0);
    host(1'b0, 2'h1, code, 1'b1);
    chk(torqueCmd.demand, 32'h0);
    host(1'b1, 2'h1, code, 1'b1);
    chk(torqueCmd.demand, 32'h0);
    host(1'b1, 2'h2, code, 1'b0);
    chk(torqueCmd.demand, presetExp[2]);
    wr(tcs_pkg::ADDR_CTRL_MODE, 32'h0000_0000);
    settle();
    chk({torqueCmd.limit, torqueCmd.demand}, 32'h0);
    wr(tcs_pkg::ADDR_LIMIT_EN, 32'h0000_0001);
    settle();
    chk(torqueCmd.limit, 32'h0000_0BB8);
    chk({31'h0, torqueCmd.limitActive}, 32'h1);
    wr(tcs_pkg::ADDR_CTRL_MODE, 32'h0000_0001);
    wr(tcs_pkg::ADDR_FULL_SCALE, 32'h0000_0064);
    host(1'b1, 2'h0, 32'sh2000, 1'b0);
    chk(torqueCmd.limit, 32'h0000_01F4);
    rd(tcs_pkg::ADDR_COMMAND, 32'h0000_01F4);
    wr(tcs_pkg::ADDR_LIMIT_EN, 32'h0000_0000);
    wr(tcs_pkg::ADDR_CTRL_MODE, 32'h0000_0002);
    host(1'b1, 2'h0, 32'sh0, 1'b0);
    wr(tcs_pkg::ADDR_SMOOTH, 32'h0000_0001);
    // Let the coefficient division finish before the step
    repeat (40) @(posedge clk_sys);
    host(1'b1, 2'h0, 32'sh4000, 1'b0);
    repeat (SAMPLES) @(posedge clk_sys);
    #1;
    d1 = torqueCmd.demand;
    chk({31'h0, d1 > 16'sh0000 && d1 < 16'sh03E8}, 32'h1);
    repeat (3 * SAMPLES) @(posedge clk_sys);
    #1;
    chk({31'h0, torqueCmd.demand > d1 && torqueCmd.demand < 16'sh03E8}, 32'h1);
    wr(tcs_pkg::ADDR_SMOOTH, 32'h0000_0000);
    settle();
    chk(torqueCmd.demand, 32'h0000_03E8);
    complete_run();
  end

  initial
  begin
    repeat (SAMPLES * 1250) @(posedge clk_sys);
    mismatches++;
    complete_run();
  end
endmodule : tcs_torque_command_select_tb_top
